// File: bench/scp_target_model.sv
// Behavioural SCSI target and rival arbiter facing the controller
`timescale 1ns/1ns
module scp_target_model
    import scp_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic [7:0]  db_o_i,
    input  wire logic [7:0]  db_oe_i,
    input  wire scp_ctl_type ctl_o_i,
    input  wire scp_ctl_type ctl_oe_i,
    input  wire logic [7:0]  rival_i,
    input  wire logic [2:0]  phase_i,
    input  wire logic        go_i,
    input  wire logic        stall_i,
    output logic [7:0]       db_i_o,
    output scp_ctl_type      ctl_i_o,
    output logic [7:0]       got_o
);
    logic [7:0] n_reg   = 8'h00;
    logic       req_reg = 1'b0;
    wire        ack     = ctl_o_i.ack & ctl_oe_i.ack;
    wire  [7:0] tdata   = (req_reg & phase_i[0]) ? 8'ha0 + n_reg : 8'h00;
    // Released lines settle at the negated level of the terminators
    assign db_i_o = (db_o_i & db_oe_i) | rival_i | tdata;
    assign ctl_i_o = '{req: req_reg, ack: ack, atn: 1'b0, sel: 1'b0,
                       bsy: ctl_o_i.bsy & ctl_oe_i.bsy, msg: phase_i[2],
                       cd: phase_i[1], io: phase_i[0]};
    initial got_o = 8'h00;
    // Interlocked request: drop on ack, raise again only after ack falls
    always @(posedge clock_i) begin
        if (req_reg && ack) begin
            req_reg <= 1'b0;
            got_o   <= db_i_o;
            n_reg   <= n_reg + 8'h01;
        end else if (!go_i) begin
            n_reg   <= 8'h00;
            req_reg <= 1'b0;
        end else if (!stall_i && !ack) begin
            req_reg <= 1'b1;
        end
    end
endmodule

// File: bench/test_scp_ctrl.sv
// Self-checking bench for the SCSI protocol controller registers
`timescale 1ns/1ns
`include "scp_map.svh"
module test_scp_ctrl
    import scp_pkg::*;
;
    logic         clock_i = 1'b0;
    logic         srst_i  = 1'b1;
    scp_host_type host    = '{1'b1, 1'b0, 1'b0, 4'h0, 8'h00};
    logic         dma_ack = 1'b0;
    logic [7:0]   dma_wd  = 8'h00;
    logic [7:0]   rival   = 8'h00;
    logic [2:0]   phase   = 3'h0;
    logic         go      = 1'b0;
    logic         stall   = 1'b0;
    logic [7:0]   rdata, db_o, db_oe, db_i, got, v, e, dma_rd;
    logic         rpar, intr, dma_request_out;
    scp_ctl_type  ctl_o, ctl_oe, ctl_i;
    logic [31:0]  seed    = 32'h495cf0ec;
    logic [31:0]  sseed   = 32'h495cf0ec;
    logic [3:0]   rwa [4] = '{4'h3, 4'hc, 4'hd, 4'he};
    int           errors = 0, checks_done = 0, cyc = 0, j, k, id, n;

    always #20 clock_i = ~clock_i;

    scp_ctrl dut_u (.clock_i(clock_i), .srst_i(srst_i), .ce_i(1'b1),
        .host_i(host), .rdata_o(rdata), .rpar_o(rpar), .intr_o(intr),
        .dma_req_o(dma_request_out), .dma_ack_i(dma_ack), .dma_wdata_i(dma_wd),
        .dma_rdata_o(dma_rd), .scsi_db_i(db_i), .scsi_db_o(db_o),
        .scsi_db_oe_o(db_oe), .scsi_ctl_i(ctl_i), .scsi_ctl_o(ctl_o),
        .scsi_ctl_oe_o(ctl_oe));
    scp_target_model tgt_u (.clock_i(clock_i), .db_o_i(db_o),
        .db_oe_i(db_oe), .ctl_o_i(ctl_o), .ctl_oe_i(ctl_oe),
        .rival_i(rival), .phase_i(phase), .go_i(go), .stall_i(stall),
        .db_i_o(db_i), .ctl_i_o(ctl_i), .got_o(got));

    function automatic logic [31:0] xs(logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Target stalls come from their own stream to keep runs repeatable
    always @(negedge clock_i) begin
        sseed = xs(sseed);
        stall = sseed[0];
    end
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(negedge clock_i);
        host = '{1'b0, 1'b0, 1'b1, a, d};
        @(negedge clock_i);
        host = '{1'b1, 1'b0, 1'b0, a, d};
    endtask
    task automatic rd(logic [3:0] a, output logic [7:0] d);
        @(negedge clock_i);
        host = '{1'b0, 1'b1, 1'b0, a, 8'h00};
        @(negedge clock_i);
        host = '{1'b1, 1'b0, 1'b0, a, 8'h00};
        @(negedge clock_i);
        d = rdata;
        chk("parity", {7'h0, rpar}, {7'h0, ~^rdata});
    endtask
    task automatic ex(string nm, logic [3:0] a, logic [7:0] x);
        rd(a, v);
        chk(nm, v, x);
    endtask
    task automatic wbit(logic [3:0] a, int b);
        v = 8'h00;
        for (k = 0; k < 300 && v[b] !== 1'b1; k++) rd(a, v);
    endtask
    task automatic count(logic [7:0] c);
        wr(4'hc, 8'h00);
        wr(4'hd, 8'h00);
        wr(4'he, c);
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (8) @(negedge clock_i);
        srst_i = 1'b0;
        ex("status", 4'h6, 8'h05);
        ex("own id", 4'h0, 8'h01);
        wr(4'h6, 8'hff);
        wr(4'h7, 8'hff);
        wr(4'h9, 8'hff);
        ex("ro status", 4'h6, 8'h05);
        ex("ro error", 4'h7, 8'h00);
        ex("ro fifo count", 4'h9, 8'h00);
        for (j = 0; j < 12; j++) begin
            seed = xs(seed);
            e = seed[7:0];
            wr(rwa[j % 4], e);
            ex("rw reg", rwa[j % 4], e);
            wr(4'h0, e);
            ex("id", 4'h0, 8'h01 << e[2:0]);
        end
        wr(4'h1, 8'h01);
        wr(4'h2, 8'h20);
        wbit(4'h4, 1);
        @(negedge clock_i);
        chk("intr on", {7'h0, intr}, 8'h01);
        wr(4'h1, 8'h00);
        @(negedge clock_i);
        chk("intr masked", {7'h0, intr}, 8'h00);
        ex("polled", 4'h4, 8'h02);
        wr(4'h4, 8'h02);
        ex("cleared", 4'h4, 8'h00);
        for (j = 0; j < 2; j++) begin
            seed = xs(seed);
            id = 1 + seed[7:0] % 6;
            rival = (j == 0) ? 8'h01 << (id - 1) : 8'h01 << (id + 1);
            wr(4'h0, id[7:0]);
            wr(4'h1, 8'h10);
            wr(4'h2, 8'h20);
            repeat (4) @(negedge clock_i);
            chk("arb enable", db_oe, 8'h01 << id);
            chk("arb id", db_o & db_oe, 8'h01 << id);
            chk("arb bsy", {7'h0, ctl_o.bsy & ctl_oe.bsy}, 8'h01);
            wbit(4'h4, (j == 0) ? 4 : 2);
            ex("arb result", 4'h4, (j == 0) ? 8'h10 : 8'h04);
            rival = 8'h00;
            wr(4'h1, 8'h80);
            wr(4'h1, 8'h00);
            wr(4'h4, 8'hff);
        end
        wr(4'h2, 8'hc0);
        @(negedge clock_i);
        chk("ack set", {ctl_o.ack, ctl_oe.ack}, 8'h03);
        wr(4'h2, 8'he0);
        @(negedge clock_i);
        chk("ack clear", {ctl_o.ack, ctl_oe.ack}, 8'h00);
        wr(4'h1, 8'h20);
        wr(4'h5, 8'hcf);
        @(negedge clock_i);
        chk("diag data", db_oe, 8'h00);
        chk("diag ctl", ctl_oe, 8'h00);
        ex("diag sense", 4'h5, 8'hcf);
        wr(4'h1, 8'h00);
        phase = 3'h5;
        ex("sense", 4'h5, 8'h05);
        phase = 3'h1;
        wr(4'h8, 8'h01);
        count(8'h0a);
        go = 1'b1;
        wr(4'h2, 8'h84);
        v = 8'h00;
        for (k = 0; k < 300 && v !== 8'h08; k++) rd(4'h9, v);
        rd(4'h6, v);
        chk("full", {7'h0, v[1]}, 8'h01);
        ex("count mid", 4'he, 8'h02);
        for (j = 0; j < 10; j++) begin
            if (j == 8) wbit(4'h4, 4);
            ex("fifo in", 4'ha, 8'ha0 + j[7:0]);
        end
        ex("count end", 4'he, 8'h00);
        go = 1'b0;
        wr(4'h4, 8'hff);
        phase = 3'h0;
        wr(4'h8, 8'h00);
        count(8'h04);
        go = 1'b1;
        wr(4'h2, 8'h80);
        repeat (3) @(negedge clock_i);
        chk("dma_request_out level", {7'h0, dma_request_out}, 8'h01);
        n = 0;
        for (j = 0; j < 300; j++) begin
            @(negedge clock_i);
            dma_ack = dma_request_out & (n < 4);
            dma_wd = 8'h50 + n[7:0];
            n += dma_ack;
        end
        dma_ack = 1'b0;
        wbit(4'h4, 4);
        chk("dma out", got, 8'h53);
        ex("dma count", 4'he, 8'h00);
        go = 1'b0;
        wr(4'h4, 8'hff);
        wr(4'h8, 8'h01);
        phase = 3'h1;
        count(8'h02);
        go = 1'b1;
        wr(4'h2, 8'h80);
        n = 0;
        for (j = 0; j < 300; j++) begin
            @(negedge clock_i);
            if (dma_ack) chk("dma in", dma_rd, 8'h9f + n[7:0]);
            dma_ack = dma_request_out & (n < 2);
            n += dma_ack;
        end
        dma_ack = 1'b0;
        wbit(4'h4, 4);
        ex("dma in count", 4'he, 8'h00);
        go = 1'b0;
        phase = 3'h0;
        wr(4'h4, 8'hff);
        count(8'h01);
        wr(4'h2, 8'h84);
        wbit(4'h4, 3);
        ex("phase error", 4'h7, 8'h04);
        give_verdict();
    end
endmodule

// File: rtl/scp_ctrl.sv
// SCSI protocol controller: host registers, FIFO, arbitration, transfer
`timescale 1ns/1ns
`include "scp_map.svh"
module scp_ctrl
    import scp_pkg::*;
(
    input  wire logic         clock_i,
    input  wire logic         srst_i,
    input  wire logic         ce_i,
    input  wire scp_host_type host_i,
    output logic [7:0]        rdata_o,
    output logic              rpar_o,
    output logic              intr_o,
    output logic              dma_req_o,
    input  wire logic         dma_ack_i,
    input  wire logic [7:0]   dma_wdata_i,
    output logic [7:0]        dma_rdata_o,
    input  wire logic [7:0]   scsi_db_i,
    output logic [7:0]        scsi_db_o,
    output logic [7:0]        scsi_db_oe_o,
    input  wire scp_ctl_type  scsi_ctl_i,
    output scp_ctl_type       scsi_ctl_o,
    output scp_ctl_type       scsi_ctl_oe_o
);

    function automatic logic odd_par(input logic [7:0] v);
        odd_par = ~(^v);
    endfunction

    function automatic logic need_more(input logic [23:0] tc,
                                       input logic [3:0]  cnt);
        need_more = tc > {20'h0, cnt};
    endfunction

    logic [7:0]    own_id_reg;
    logic [7:0]    ctl_reg;
    logic [7:0]    cmd_reg;
    logic [7:0]    transfer_mode_cfg_reg;
    logic [7:0]    interrupt_sense_clear_reg;
    logic [7:0]    diag_reg;
    logic [7:0]    error_status_reg;
    logic [7:0]    phase_control_reg;
    logic [7:0]    temp_reg;
    logic [7:0]    external_buffer_port_reg;
    logic [23:0]   tc_reg;
    logic [7:0]    fifo_mem [0:7];
    logic [2:0]    wptr_reg;
    logic [2:0]    rptr_reg;
    logic [3:0]    fcnt_reg;
    logic [6:0]    arb_cnt_reg;
    logic          conn_reg;
    logic          dir_in_reg;
    logic          prg_reg;
    logic          man_ack_reg;
    logic [7:0]    rdata_reg;
    logic          rpar_reg;
    logic          intr_reg;
    logic          dma_req_reg;
    logic [7:0]    dma_rdata_reg;
    logic [7:0]    db_out_reg;
    logic [7:0]    db_oe_reg;
    scp_ctl_type   ctl_out_reg;
    scp_ctl_type   ctl_oe_reg;
    scp_state_type state_reg;
    scp_state_type state_next;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i || !ce_i);

    // Host access decode, only while chip select is low
    wire        host_acc = ce_i & ~host_i.cs_n; // RULE19
    wire        hwr      = host_acc & host_i.wr;
    wire        hrd      = host_acc & host_i.rd;
    wire [15:0] wsel     = hwr ? (16'h0001 << host_i.sel) : 16'h0000; // RULE2
    wire [15:0] rsel     = hrd ? (16'h0001 << host_i.sel) : 16'h0000;

    wire        hold     = ctl_reg[`SCP_CTL_RST_DIS] |
                           ctl_reg[`SCP_CTL_CTRL_RST]; // RULE16
    wire        diag     = ctl_reg[`SCP_CTL_DIAG];
    wire        run      = ce_i & ~hold;

    // Diagnostic mode replaces the bus with register bits and loopback
    wire scp_ctl_type sense = diag ?
        scp_ctl_type'({diag_reg[7:6], 2'b00, diag_reg[3:0]}) :
        scsi_ctl_i; // RULE11
    wire [7:0]  db_sense = diag ? db_out_reg : scsi_db_i;

    wire [7:0]  own_hot  = 8'h01 << own_id_reg[2:0];
    wire [7:0]  above    = ~((own_hot << 1) - 8'h01);
    wire        arb_lost = |(db_sense & ~own_hot & above); // RULE12 RULE13
    wire        arb_done = (state_reg == ST_ARB) &
                           (arb_cnt_reg == 7'(`SCP_ARB_CYC - 1));

    wire [2:0]  cmd_code  = host_i.wdata[7:5];
    wire        cmd_wr    = wsel[`SCP_OFF_CMD] & run;
    wire        idle      = state_reg == ST_IDLE;
    wire        arb_allow = ctl_reg[`SCP_CTL_ARB_EN];
    wire        start_arb = cmd_wr & idle &
                            (cmd_code == `SCP_CMD_SELECT) & arb_allow;
    wire        arb_refused = cmd_wr & (cmd_code == `SCP_CMD_SELECT) &
                              ~(idle & arb_allow);
    wire        start_xfer = cmd_wr & idle & (cmd_code == `SCP_CMD_XFER);
    wire        phase_ok  = {sense.msg, sense.cd, sense.io} == phase_control_reg[2:0];
    wire        tc_zero   = tc_reg == 24'h000000;
    wire        xfer_act  = (state_reg == ST_XREQ) | (state_reg == ST_XACK);

    // FIFO pointers and flags
    wire        fifo_full  = fcnt_reg == `SCP_FIFO_DEPTH; // RULE3
    wire        fifo_empty = fcnt_reg == 4'h0;
    wire [7:0]  fifo_head  = fifo_mem[rptr_reg];

    // One SCSI byte moves when the target raises its request
    wire byte_step = run & (state_reg == ST_XREQ) & sense.req &
                     (dir_in_reg ? ~fifo_full : ~fifo_empty); // RULE9
    wire dma_take  = run & dma_ack_i & dma_req_o & xfer_act & ~prg_reg;
    wire h_push    = run & wsel[`SCP_OFF_FIFO] & ~dir_in_reg & ~fifo_full &
                     need_more(tc_reg, fcnt_reg);
    wire h_pop     = run & rsel[`SCP_OFF_FIFO] & dir_in_reg & ~fifo_empty;
    wire d_push    = dma_take & ~dir_in_reg & ~fifo_full &
                     need_more(tc_reg, fcnt_reg); // RULE10
    wire d_pop     = dma_take & dir_in_reg & ~fifo_empty;
    wire push      = dir_in_reg ? byte_step : (h_push | d_push);
    wire pop       = dir_in_reg ? (h_pop | d_pop) : byte_step;
    wire [7:0] push_data = dir_in_reg ? db_sense :
                           (d_push ? dma_wdata_i : host_i.wdata);

    // DMA request uses next-cycle FIFO state so a steady ack never overruns
    wire [3:0]  fcnt_next = fcnt_reg + 4'(push) - 4'(pop);
    wire [23:0] tc_after  = tc_reg - 24'(byte_step);
    wire dma_req_next = run & xfer_act & ~prg_reg &
                        (dir_in_reg ? (fcnt_next != 4'h0) :
                         ((fcnt_next != `SCP_FIFO_DEPTH) &
                          need_more(tc_after, fcnt_next))); // RULE18

    wire xfer_end  = run & (state_reg == ST_XACK) & ~sense.req & tc_zero;
    wire ev_done   = xfer_end | (start_xfer & phase_ok & tc_zero) |
                     (arb_done & ~arb_lost & run);
    wire ev_phase  = start_xfer & ~phase_ok;
    wire ev_lost   = arb_done & arb_lost & run;

    wire [7:0] int_set = ({7'h00, ev_done} << `SCP_INT_CMD_DONE) |
                         ({7'h00, ev_phase} << `SCP_INT_SVC_REQ) |
                         ({7'h00, ev_lost} << `SCP_INT_TIMEOUT) |
                         ({7'h00, arb_refused} << `SCP_INT_HARD_ERR);
    wire [7:0] int_clr = wsel[`SCP_OFF_INTERRUPT_SENSE_CLEAR] ? host_i.wdata : 8'h00;
    // A set in the same cycle as its clear wins
    wire [7:0] interrupt_sense_clear_next = (interrupt_sense_clear_reg & ~int_clr) | int_set; // RULE1 RULE7

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_arb) begin
                    state_next = ST_ARB;
                end else if (start_xfer & phase_ok & ~tc_zero) begin
                    state_next = ST_XREQ;
                end
            end
            ST_ARB: begin
                if (arb_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_XREQ: begin
                if (byte_step) begin
                    state_next = ST_XACK;
                end
            end
            ST_XACK: begin
                if (~sense.req) begin
                    state_next = tc_zero ? ST_IDLE : ST_XREQ;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Read data table; offsets 5 and 11 read back bus sense, not the written value; unused bits read as zero
    wire [7:0] rd_tab [0:15];
    assign rd_tab[0]  = own_hot; // RULE6
    assign rd_tab[1]  = ctl_reg;
    assign rd_tab[2]  = cmd_reg;
    assign rd_tab[3]  = transfer_mode_cfg_reg;
    assign rd_tab[4]  = interrupt_sense_clear_reg;
    assign rd_tab[5]  = sense; // RULE6
    assign rd_tab[6]  = {conn_reg, 1'b0, ~idle, xfer_act, 1'b0, tc_zero,
                         fifo_full, fifo_empty};
    assign rd_tab[7]  = error_status_reg;
    assign rd_tab[8]  = {~sense.bsy & ~sense.sel, 4'h0, phase_control_reg[2:0]};
    assign rd_tab[9]  = {4'h0, fcnt_reg};
    assign rd_tab[10] = fifo_head;
    assign rd_tab[11] = db_sense;
    assign rd_tab[12] = tc_reg[23:16];
    assign rd_tab[13] = tc_reg[15:8];
    assign rd_tab[14] = tc_reg[7:0];
    assign rd_tab[15] = external_buffer_port_reg;
    wire [7:0] rd_val = rd_tab[host_i.sel]; // RULE5

    // Bus drive: arbitration ID, transfer data, manual data
    wire man_ack_next = ~idle ? man_ack_reg :
        (cmd_wr & (cmd_code == `SCP_CMD_SET_ACK)) ? 1'b1 :
        (cmd_wr & (cmd_code == `SCP_CMD_RST_ACK)) ? 1'b0 : man_ack_reg; // RULE8
    wire man_drive = man_ack_reg & ~sense.io;
    wire [7:0] db_out_next = (state_reg == ST_ARB) ? own_hot :
                             (byte_step & ~dir_in_reg) ? fifo_head :
                             (idle & man_drive) ? temp_reg : db_out_reg;
    wire [7:0] db_oe_next = diag ? 8'h00 :
        (state_reg == ST_ARB) ? own_hot : // RULE12
        ((xfer_act & ~dir_in_reg) | (idle & man_drive)) ? 8'hff :
        8'h00; // RULE14 RULE15
    wire scp_ctl_type ctl_drv = '{req: 1'b0,
        ack: (state_reg == ST_XACK) | man_ack_reg,
        atn: 1'b0, sel: 1'b0,
        bsy: (state_reg == ST_ARB) | conn_reg,
        msg: 1'b0, cd: 1'b0, io: 1'b0};

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            own_id_reg <= `SCP_RST_BYTE;
            ctl_reg    <= `SCP_RST_BYTE;
            cmd_reg    <= `SCP_RST_BYTE;
            transfer_mode_cfg_reg   <= `SCP_RST_BYTE;
            diag_reg   <= `SCP_RST_BYTE;
            phase_control_reg   <= `SCP_RST_BYTE;
            temp_reg   <= `SCP_RST_BYTE;
            external_buffer_port_reg   <= `SCP_RST_BYTE;
        end else if (ce_i) begin
            // Offsets 6, 7 and 9 have no write path
            if (wsel[`SCP_OFF_OWN_ID]) own_id_reg <= {5'h00, host_i.wdata[2:0]};
            if (wsel[`SCP_OFF_CTL])    ctl_reg    <= host_i.wdata; // RULE16
            if (cmd_wr)                cmd_reg    <= host_i.wdata;
            if (wsel[`SCP_OFF_TRANSFER_MODE_CFG])   transfer_mode_cfg_reg   <= host_i.wdata;
            if (wsel[`SCP_OFF_PHASE_SENSE_DIAG_CTRL])   diag_reg   <= host_i.wdata; // RULE6
            if (wsel[`SCP_OFF_PHASE_CONTROL])   phase_control_reg   <= host_i.wdata;
            if (wsel[`SCP_OFF_TEMP])   temp_reg   <= host_i.wdata;
            if (wsel[`SCP_OFF_EXTERNAL_BUFFER_PORT])   external_buffer_port_reg   <= host_i.wdata; // RULE4
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            tc_reg <= `SCP_RST_COUNT;
        end else if (ce_i) begin
            if (byte_step) begin
                tc_reg <= tc_reg - 24'h000001; // RULE17
            end else begin
                if (wsel[`SCP_OFF_TC_HIGH]) tc_reg[23:16] <= host_i.wdata;
                if (wsel[`SCP_OFF_TC_MID])  tc_reg[15:8]  <= host_i.wdata;
                if (wsel[`SCP_OFF_TC_LOW])  tc_reg[7:0]   <= host_i.wdata;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (ce_i & push) begin
            fifo_mem[wptr_reg] <= push_data;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            wptr_reg <= 3'h0;
            rptr_reg <= 3'h0;
            fcnt_reg <= 4'h0;
        end else if (ce_i) begin
            if (hold) begin
                wptr_reg <= 3'h0;
                rptr_reg <= 3'h0;
                fcnt_reg <= 4'h0;
            end else begin
                wptr_reg <= wptr_reg + 3'(push);
                rptr_reg <= rptr_reg + 3'(pop);
                fcnt_reg <= fcnt_reg + 4'(push) - 4'(pop);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_reg   <= ST_IDLE;
            arb_cnt_reg <= 7'h00;
            conn_reg    <= 1'b0;
            dir_in_reg  <= 1'b0;
            prg_reg     <= 1'b0;
            man_ack_reg <= 1'b0;
            interrupt_sense_clear_reg    <= `SCP_RST_BYTE;
            error_status_reg    <= `SCP_RST_BYTE;
        end else if (ce_i) begin
            interrupt_sense_clear_reg <= interrupt_sense_clear_next;
            if (hold) begin
                state_reg   <= ST_IDLE;
                arb_cnt_reg <= 7'h00;
                conn_reg    <= 1'b0;
                man_ack_reg <= 1'b0;
                error_status_reg    <= `SCP_RST_BYTE;
            end else begin
                state_reg   <= state_next;
                man_ack_reg <= man_ack_next;
                arb_cnt_reg <= (state_reg == ST_ARB) ?
                               arb_cnt_reg + 7'h01 : 7'h00;
                if (arb_done) conn_reg <= ~arb_lost; // RULE13
                if (start_xfer) begin
                    dir_in_reg <= sense.io;
                    prg_reg    <= host_i.wdata[`SCP_CMD_PRG_BIT]; // RULE9
                end
                if (ev_phase) error_status_reg[`SCP_ERROR_STATUS_PHASE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_reg     <= `SCP_RST_BYTE;
            rpar_reg      <= 1'b1;
            intr_reg      <= 1'b0;
            dma_req_reg   <= 1'b0;
            dma_rdata_reg <= `SCP_RST_BYTE;
            db_out_reg    <= `SCP_RST_BYTE;
            db_oe_reg     <= `SCP_RST_BYTE;
            ctl_out_reg   <= '0;
            ctl_oe_reg    <= '0;
        end else if (ce_i) begin
            if (hrd) begin
                rdata_reg <= rd_val;
                rpar_reg  <= odd_par(rd_val);
            end
            intr_reg    <= ctl_reg[`SCP_CTL_INT_EN] & (|interrupt_sense_clear_reg); // RULE7
            dma_req_reg <= dma_req_next; // RULE18
            if (d_pop) dma_rdata_reg <= fifo_head; // RULE10
            db_out_reg  <= db_out_next;
            db_oe_reg   <= db_oe_next;
            ctl_out_reg <= ctl_drv;
            ctl_oe_reg  <= diag ? scp_ctl_type'(8'h00) : ctl_drv; // RULE11
        end
    end

    assign rdata_o       = rdata_reg;
    assign rpar_o        = rpar_reg;
    assign intr_o        = intr_reg;
    assign dma_req_o     = dma_req_reg;
    assign dma_rdata_o   = dma_rdata_reg;
    assign scsi_db_o     = db_out_reg;
    assign scsi_db_oe_o  = db_oe_reg;
    assign scsi_ctl_o    = ctl_out_reg;
    assign scsi_ctl_oe_o = ctl_oe_reg;

    a_fifo_bound: assert property (fcnt_reg <= 4'h8) // RULE3
        else $error("fifo count above eight");
    a_ro_ignored: assert property (hwr && host_i.sel == `SCP_OFF_ERROR_STATUS // RULE4
        && !hold |=> error_status_reg == $past(error_status_reg))
        else $error("write to error status changed it");
    a_read_phase: assert property (hrd && host_i.sel == `SCP_OFF_PHASE_SENSE_DIAG_CTRL // RULE6
        |=> rdata_o == $past(sense))
        else $error("phase sense read mismatch");
    a_intr_mask: assert property (!ctl_reg[0] ##1 !ctl_reg[0] // RULE7
        |-> !intr_o)
        else $error("interrupt raised while disabled");
    a_prg_no_dma: assert property (prg_reg && xfer_act ##1 prg_reg // RULE9
        |-> !dma_req_o)
        else $error("dma request in program mode");
    a_diag_quiet: assert property (diag |=> scsi_db_oe_o == 8'h00 // RULE11
        && scsi_ctl_oe_o == '0)
        else $error("bus driven in diagnostic mode");
    a_arb_own_line: assert property (state_reg == ST_ARB && !diag // RULE12
        |=> scsi_db_oe_o == $past(own_hot))
        else $error("arbitration drives wrong line");
    a_arb_lost: assert property (arb_done && arb_lost && !hold // RULE13
        |=> !conn_reg && interrupt_sense_clear_reg[`SCP_INT_TIMEOUT])
        else $error("lost arbitration not reported");
    a_ctl_reset: assert property (ctl_reg[6] |=> state_reg == ST_IDLE // RULE16
        && fcnt_reg == 4'h0)
        else $error("control reset did not clear");
    a_count_step: assert property (byte_step // RULE17
        |=> tc_reg == $past(tc_reg) - 24'h000001)
        else $error("byte counter did not decrement");
    a_dma_level: assert property (xfer_act && dir_in_reg && !prg_reg // RULE18
        && fcnt_next != 4'h0 && !hold |=> dma_req_o)
        else $error("dma request dropped with data present");

    c_arb_win: cover property (arb_done && !arb_lost);
    c_xfer_done: cover property (xfer_end);
    c_dma_take: cover property (dma_take ##1 dma_take);
    c_manual_ack: cover property (man_ack_reg && idle);

endmodule

// File: rtl/scp_map.svh
// Register offsets, field positions, reset values and timing counts
// What this block does
// RULE1 - Register bits use positive sense
// RULE2 - Sixteen registers, four address lines
// RULE3 - Eight-byte FIFO decouples host and SCSI
// RULE4 - Writes to read-only registers are ignored
// RULE5 - Reads of write-only locations are undefined
// RULE6 - Some addresses differ for read and write
// RULE7 - Interrupt, polled or mixed status operation
// RULE8 - Manual mode: software drives handshake directly
// RULE9 - Program mode: hardware handshake, host moves bytes
// RULE10 - DMA mode uses request/acknowledge interface
// RULE11 - Diagnostic mode simulates SCSI bus events
// RULE12 - Arbitrate with own ID, bit 7 highest
// RULE13 - Sample other seven lines to decide winner
// RULE14 - Differential variant: separate in/out ports
// RULE15 - Single-ended variant: bidirectional port, tri-state
// RULE16 - Control register bit order as documented
// RULE17 - 24-bit counter decrements per SCSI byte
// RULE18 - DMA request held as level, not pulsed
// RULE19 - Host accesses only with chip select, stable
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

`define SCP_OFF_OWN_ID    4'h0
`define SCP_OFF_CTL       4'h1
`define SCP_OFF_CMD       4'h2
`define SCP_OFF_TRANSFER_MODE_CFG      4'h3
`define SCP_OFF_INTERRUPT_SENSE_CLEAR      4'h4
`define SCP_OFF_PHASE_SENSE_DIAG_CTRL      4'h5
`define SCP_OFF_CONTROLLER_STATUS      4'h6
`define SCP_OFF_ERROR_STATUS      4'h7
`define SCP_OFF_PHASE_CONTROL      4'h8
`define SCP_OFF_MBC       4'h9
`define SCP_OFF_FIFO      4'ha
`define SCP_OFF_TEMP      4'hb
`define SCP_OFF_TC_HIGH   4'hc
`define SCP_OFF_TC_MID    4'hd
`define SCP_OFF_TC_LOW    4'he
`define SCP_OFF_EXTERNAL_BUFFER_PORT      4'hf

`define SCP_CTL_RST_DIS   7
`define SCP_CTL_CTRL_RST  6
`define SCP_CTL_DIAG      5
`define SCP_CTL_ARB_EN    4
`define SCP_CTL_PAR_EN    3
`define SCP_CTL_SEL_EN    2
`define SCP_CTL_RESEL_EN  1
`define SCP_CTL_INT_EN    0

`define SCP_INT_CMD_DONE  4
`define SCP_INT_SVC_REQ   3
`define SCP_INT_TIMEOUT   2
`define SCP_INT_HARD_ERR  1

`define SCP_ERROR_STATUS_PHASE    2

`define SCP_CMD_PRG_BIT   2
`define SCP_CMD_SELECT    3'h1
`define SCP_CMD_XFER      3'h4
`define SCP_CMD_SET_ACK   3'h6
`define SCP_CMD_RST_ACK   3'h7

`define SCP_RST_BYTE      8'h00
`define SCP_RST_COUNT     24'h000000
`define SCP_FIFO_DEPTH    4'h8

`define SCP_CLK_NS        40
`define SCP_ARB_DELAY_NS  2400
`define SCP_ARB_CYC       ((`SCP_ARB_DELAY_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)

`endif

// File: rtl/scp_pkg.sv
// Types shared by the SCSI protocol controller register block
package scp_pkg;

    typedef struct packed {
        logic req;
        logic ack;
        logic atn;
        logic sel;
        logic bsy;
        logic msg;
        logic cd;
        logic io;
    } scp_ctl_type;

    typedef struct packed {
        logic       cs_n;
        logic       rd;
        logic       wr;
        logic [3:0] sel;
        logic [7:0] wdata;
    } scp_host_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARB  = 4'b0010,
        ST_XREQ = 4'b0100,
        ST_XACK = 4'b1000
    } scp_state_type;

endpackage
